//--- core/ssc_top.sv
// Sample sequencer control: four sequencers, arbiter, averager, results.
// Assumes a converter on the same clock that answers each start with done.
`timescale 1ns/10ps
module ssc_top #(
	parameter int DATA_W  = ssc_pkg::DATA_W,
	parameter int NUM_EVT = ssc_pkg::NUM_EVT
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic [7:0]         i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic [31:0]             o_rdata,
	input  wire logic [NUM_EVT-1:0] i_trig_evt,
	input  wire logic               i_trig_pin,
	output logic                    o_conv_start,
	output logic [2:0]              o_conv_channel,
	input  wire logic               i_conv_done,
	input  wire logic [DATA_W-1:0]  i_conv_data,
	output logic [3:0]              o_seq_irq
);
	localparam int NSEQ = ssc_pkg::NSEQ;
	localparam int LW   = ssc_pkg::LVL_W;
	localparam int CW   = ssc_pkg::CFG_W;

	typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT, S_AVG} ssc_state_t;

	ssc_state_t    state_q;
	logic [3:0]    seq_en_q;
	logic [2:0]    avg_exp_q;
	logic [15:0]   trig_sel_q;
	logic [7:0]    prio_q;
	logic [3:0]    int_raw_q;
	logic [3:0]    int_en_q;
	logic [3:0]    ovf_q;
	logic [3:0]    pend_q;
	logic [CW-1:0] step_cfg_q [NSEQ][ssc_pkg::MAX_STEPS];
	logic [1:0]    cur_q;
	logic [2:0]    step_q;
	logic [2:0]    chan_q;
	logic [31:0]   rdata_q;
	logic          pin_s1_q;
	logic          pin_s2_q;
	logic          pin_s3_q;

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	wire wr_en    = i_wr && i_addr == ssc_pkg::OFF_SEQ_ENABLE;
	wire wr_avg   = i_wr && i_addr == ssc_pkg::OFF_AVG_FACTOR;
	wire wr_trig  = i_wr && i_addr == ssc_pkg::OFF_TRIG_SEL;
	wire wr_prio  = i_wr && i_addr == ssc_pkg::OFF_PRIORITY;
	wire wr_proc  = i_wr && i_addr == ssc_pkg::OFF_PROC_TRIG;
	wire wr_iclr  = i_wr && i_addr == ssc_pkg::OFF_INT_RAW;
	wire wr_ien   = i_wr && i_addr == ssc_pkg::OFF_INT_EN;
	wire wr_oclr  = i_wr && i_addr == ssc_pkg::OFF_OVERFLOW;
	wire wr_step  = i_wr && i_addr[ssc_pkg::STEP_REGION];
	wire [1:0] a_seq  = i_addr[ssc_pkg::STEP_SEQ_LSB +: 2];
	wire [2:0] a_step = i_addr[ssc_pkg::STEP_IDX_LSB +: 3];

	// Unlisted factor values leave the setting unchanged
	function automatic logic [3:0] ssc_exp_of(input logic [31:0] f);
		logic [3:0] r;
		r = 4'h8;
		for (int k = 0; k <= 6; k++)
			if (f == (32'h1 << k) && k != 0)
				r = 4'(k);
		if (f == 32'h0)
			r = 4'h0;
		return r;
	endfunction
	wire [3:0] new_exp = ssc_exp_of(i_wdata);

	// Channel codes above the sensor fold onto the sensor
	wire [2:0] wch = i_wdata[2:0] > ssc_pkg::CH_TEMP ? ssc_pkg::CH_TEMP : i_wdata[2:0];
	wire [CW-1:0] step_wval = {i_wdata[ssc_pkg::CFG_IE_BIT], i_wdata[ssc_pkg::CFG_LAST_BIT], wch};

	////////////////////////////////////////////////////////////////////////////
	// Triggers
	wire pin_rise = pin_s2_q && !pin_s3_q;
	wire busy     = state_q != S_IDLE;
	logic [3:0] accept;
	logic [3:0] fifo_nempty;
	logic [3:0] fifo_full;
	logic [3:0] fifo_pop;
	logic [DATA_W-1:0] fifo_data [NSEQ];
	logic [LW-1:0]     fifo_lvl  [NSEQ];

	for (genvar i = 0; i < NSEQ; i++) begin : g_trig
		wire [3:0] sel   = trig_sel_q[4*i +: 4];
		wire [3:0] eoff  = sel - ssc_pkg::TRIG_EVT_FIRST;
		wire is_evt      = sel >= ssc_pkg::TRIG_EVT_FIRST && sel <= ssc_pkg::TRIG_EVT_LAST;
		wire hit_proc    = sel == ssc_pkg::TRIG_PROCESSOR && wr_proc && i_wdata[i];
		wire hit_evt     = is_evt && i_trig_evt[eoff[2:0]];
		wire hit         = hit_proc || hit_evt || (sel == ssc_pkg::TRIG_PIN && pin_rise) ||
			sel == ssc_pkg::TRIG_ALWAYS;
		// Re-triggers during a pending or running pass are absorbed
		assign accept[i] = seq_en_q[i] && hit && !pend_q[i] && !(busy && cur_q == 2'(i));
	end

	////////////////////////////////////////////////////////////////////////////
	// Arbiter: lowest priority value wins; ties go to the lower index
	function automatic logic [2:0] ssc_pick(input logic [3:0] p, input logic [7:0] pr);
		logic [2:0] best;
		logic [1:0] bp;
		best = 3'h4;
		bp   = 2'h3;
		for (int k = 0; k < 4; k++)
			if (p[k] && (best[2] || pr[2*k +: 2] < bp)) begin
				best = 3'(k);
				bp   = pr[2*k +: 2];
			end
		return best;
	endfunction
	wire [2:0] pick  = ssc_pick(pend_q, prio_q);
	wire       grant = state_q == S_IDLE && !pick[2];

	////////////////////////////////////////////////////////////////////////////
	// Step sequencing
	ssc_sample_if #(.W(DATA_W)) conv_if ();
	ssc_sample_if #(.W(DATA_W)) avg_if ();

	wire [CW-1:0] cfg_cur   = step_cfg_q[cur_q][step_q];
	wire          step_ie   = cfg_cur[ssc_pkg::CFG_IE_BIT];
	wire          depth_end = step_q == 3'(ssc_pkg::seq_depth(int'(cur_q)) - 1);
	wire          seq_end   = cfg_cur[ssc_pkg::CFG_LAST_BIT] || depth_end;
	wire          result    = state_q == S_AVG && avg_if.valid;
	wire [2:0]    step_nxt  = step_q + 3'h1;
	wire [1:0]    ld_seq    = grant ? pick[1:0] : cur_q;
	wire [2:0]    ld_step   = grant ? 3'h0 : (result ? step_nxt : step_q);
	wire [CW-1:0] cfg_ld    = step_cfg_q[ld_seq][ld_step];

	assign conv_if.valid = state_q == S_WAIT && i_conv_done;
	assign conv_if.data  = i_conv_data;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_q <= S_IDLE;
			cur_q   <= '0;
			step_q  <= '0;
			chan_q  <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: if (grant) begin
					state_q <= S_START;
					cur_q   <= pick[1:0];
					step_q  <= '0;
					chan_q  <= cfg_ld[2:0];
				end
				S_START: state_q <= S_WAIT;
				S_WAIT:  if (i_conv_done) state_q <= S_AVG;
				// No result yet: convert the same step again
				S_AVG: if (result && seq_end) begin
					state_q <= S_IDLE;
				end else begin
					state_q <= S_START;
					step_q  <= ld_step;
					chan_q  <= cfg_ld[2:0];
				end
			endcase
		end
	end

	ssc_avg #(.W(DATA_W)) u_avg (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_exp   (avg_exp_q),
		.i_clear (wr_avg),
		.smp     (conv_if.dst),
		.res     (avg_if.src)
	);

	for (genvar i = 0; i < NSEQ; i++) begin : g_fifo
		ssc_sample_if #(.W(DATA_W)) push_if ();
		assign push_if.valid = result && cur_q == 2'(i);
		assign push_if.data  = avg_if.data;
		assign fifo_pop[i]   = i_rd && i_addr == ssc_pkg::OFF_FIFO_DATA + 8'(4 * i);
		assign fifo_nempty[i] = fifo_lvl[i] != '0;
		ssc_fifo #(.DEPTH(ssc_pkg::seq_depth(i)), .W(DATA_W), .LW(LW)) u_fifo (
			.i_clk   (i_clk),
			.i_rst_n (i_rst_n),
			.push    (push_if.dst),
			.i_pop   (fifo_pop[i]),
			.o_data  (fifo_data[i]),
			.o_level (fifo_lvl[i]),
			.o_full  (fifo_full[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags: every hardware set wins over a same-cycle clear
	wire [3:0] dec_cur  = 4'h1 << cur_q;
	wire [3:0] int_set  = (result && step_ie) ? dec_cur : 4'h0;
	wire [3:0] ovf_set  = (accept & fifo_nempty) | ((result ? dec_cur : 4'h0) & fifo_full);
	wire [3:0] pend_clr = grant ? 4'h1 << pick[1:0] : 4'h0;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			int_raw_q <= '0;
			ovf_q     <= '0;
			pend_q    <= '0;
		end else begin
			int_raw_q <= (int_raw_q & ~(wr_iclr ? i_wdata[3:0] : 4'h0)) | int_set;
			ovf_q     <= (ovf_q & ~(wr_oclr ? i_wdata[3:0] : 4'h0)) | ovf_set;
			pend_q    <= (pend_q & ~pend_clr) | accept;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			seq_en_q   <= '0;
			avg_exp_q  <= ssc_pkg::AVG_OFF;
			trig_sel_q <= ssc_pkg::TRIG_SEL_RST;
			prio_q     <= ssc_pkg::PRIO_RST;
			int_en_q   <= '0;
			for (int s = 0; s < NSEQ; s++)
				for (int t = 0; t < ssc_pkg::MAX_STEPS; t++)
					step_cfg_q[s][t] <= '0;
		end else begin
			if (wr_en)   seq_en_q   <= i_wdata[3:0];
			if (wr_avg && !new_exp[3]) avg_exp_q <= new_exp[2:0];
			if (wr_trig) trig_sel_q <= i_wdata[15:0];
			if (wr_prio) prio_q     <= i_wdata[7:0];
			if (wr_ien)  int_en_q   <= i_wdata[3:0];
			if (wr_step) step_cfg_q[a_seq][a_step] <= step_wval;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= i_trig_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path, one cycle latency
	wire masked_status_select = i_addr == ssc_pkg::OFF_INT_MASKED;
	wire [3:0]  int_masked = int_raw_q & int_en_q;
	wire [31:0] fac_rd     = avg_exp_q == ssc_pkg::AVG_OFF ? 32'h0 : 32'h1 << avg_exp_q;
	wire [31:0] lvl_rd     = {16'h0, fifo_lvl[3], fifo_lvl[2], fifo_lvl[1], fifo_lvl[0]};
	wire [1:0]  fsel       = 2'((i_addr - ssc_pkg::OFF_FIFO_DATA) >> 2);
	wire        fifo_rd    = i_addr >= ssc_pkg::OFF_FIFO_DATA && i_addr < ssc_pkg::OFF_FIFO_LEVEL &&
		i_addr[1:0] == 2'h0;
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0;
		if (i_addr[ssc_pkg::STEP_REGION])
			rd_mux = {27'h0, step_cfg_q[a_seq][a_step]};
		else if (fifo_rd)
			rd_mux = {20'h0, fifo_data[fsel]};
		else if (masked_status_select)
			rd_mux = {28'h0, int_masked};
		else
			unique case (i_addr)
				ssc_pkg::OFF_SEQ_ENABLE: rd_mux = {28'h0, seq_en_q};
				ssc_pkg::OFF_AVG_FACTOR: rd_mux = fac_rd;
				ssc_pkg::OFF_TRIG_SEL:   rd_mux = {16'h0, trig_sel_q};
				ssc_pkg::OFF_PRIORITY:   rd_mux = {24'h0, prio_q};
				ssc_pkg::OFF_INT_RAW:    rd_mux = {28'h0, int_raw_q};
				ssc_pkg::OFF_INT_EN:     rd_mux = {28'h0, int_en_q};
				ssc_pkg::OFF_OVERFLOW:   rd_mux = {28'h0, ovf_q};
				ssc_pkg::OFF_FIFO_LEVEL: rd_mux = lvl_rd;
				default:                 rd_mux = 32'h0;
			endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			rdata_q <= '0;
		else
			rdata_q <= i_rd ? rd_mux : 32'h0;
	end

	assign o_rdata        = rdata_q;
	assign o_conv_start   = state_q == S_START;
	assign o_conv_channel = chan_q;
	assign o_seq_irq      = int_masked;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [6:0] smp_cnt_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || result || wr_avg)
			smp_cnt_q <= '0;
		else if (conv_if.valid)
			smp_cnt_q <= smp_cnt_q + 7'h01;
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_ie_result;
		result && step_ie;
	endsequence
	sequence s_raw_up(logic [1:0] c);
		int_raw_q[c] && o_seq_irq[c] == int_en_q[c];
	endsequence

	step_irq_set_a: assert property (s_ie_result |=> s_raw_up($past(cur_q)))
		else $error("step interrupt flag did not raise status");
	irq_clear_a: assert property (wr_iclr && i_wdata[0] && !int_set[0] |=> !int_raw_q[0])
		else $error("interrupt clear did not deassert");
	rate_factor_a: assert property (result && !$past(wr_avg) |->
		smp_cnt_q == 7'h01 << avg_exp_q)
		else $error("result not after factor conversions");
	proc_gate_a: assert property (wr_proc && i_wdata[1] && !pend_q[1] && !pin_rise &&
		i_trig_evt == '0 && trig_sel_q[7:4] != ssc_pkg::TRIG_PROCESSOR &&
		trig_sel_q[7:4] != ssc_pkg::TRIG_ALWAYS |=> !pend_q[1])
		else $error("processor trigger started unselected sequence");
	ovf_sticky_a: assert property (accept[3] && fifo_nempty[3] |=> ovf_q[3])
		else $error("overflow not flagged");
	reset_state_a: assert property ($rose(i_rst_n) |->
		avg_exp_q == ssc_pkg::AVG_OFF && int_en_q == 4'h0 && int_raw_q == 4'h0)
		else $error("reset values wrong");
	chan_follow_a: assert property (o_conv_start |->
		o_conv_channel == cfg_cur[2:0] && o_conv_channel <= ssc_pkg::CH_TEMP)
		else $error("converter channel not from step");
	depth_bound_a: assert property (busy |->
		step_q < 3'(ssc_pkg::seq_depth(int'(cur_q)) - 1) || depth_end)
		else $error("step index past sequence depth");
	trig_pend_a: assert property (accept[2] && !grant |=> pend_q[2])
		else $error("accepted trigger not pending");
	for (genvar k = 0; k < NSEQ; k++) begin : g_prio_chk
		prio_pick_a: assert property (grant && pend_q[k] |->
			prio_q[2*k +: 2] >= prio_q[2*pick[1:0] +: 2])
			else $error("lower priority sequence granted");
	end
endmodule

//--- shared/ssc_pkg.sv
// Constants, register map and field layout of the sample sequencer control.
// Assumes a 32-bit register port with byte offsets and one system clock.
package ssc_pkg;

	localparam int NSEQ      = 4;
	localparam int MAX_STEPS = 8;
	localparam int DATA_W    = 12;
	localparam int CH_W      = 3;
	localparam int NUM_EVT   = 8;
	localparam int LVL_W     = 4;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] OFF_SEQ_ENABLE = 8'h00;
	localparam logic [7:0] OFF_AVG_FACTOR = 8'h04;
	localparam logic [7:0] OFF_TRIG_SEL   = 8'h08;
	localparam logic [7:0] OFF_PRIORITY   = 8'h0c;
	localparam logic [7:0] OFF_PROC_TRIG  = 8'h10;
	localparam logic [7:0] OFF_INT_RAW    = 8'h14;
	localparam logic [7:0] OFF_INT_EN     = 8'h18;
	localparam logic [7:0] OFF_INT_MASKED = 8'h1c;
	localparam logic [7:0] OFF_OVERFLOW   = 8'h20;
	localparam logic [7:0] OFF_FIFO_DATA  = 8'h24;
	localparam logic [7:0] OFF_FIFO_LEVEL = 8'h34;
	localparam int         STEP_REGION    = 7;
	localparam int         STEP_SEQ_LSB   = 5;
	localparam int         STEP_IDX_LSB   = 2;

	////////////////////////////////////////////////////////////////////////////
	// Step configuration word
	localparam int CFG_CH_LSB   = 0;
	localparam int CFG_LAST_BIT = 3;
	localparam int CFG_IE_BIT   = 4;
	localparam int CFG_W        = 5;
	localparam logic [CH_W-1:0] CH_TEMP = 3'h4;

	////////////////////////////////////////////////////////////////////////////
	// Trigger source codes, priority and averaging
	localparam logic [3:0] TRIG_PROCESSOR = 4'h0;
	localparam logic [3:0] TRIG_EVT_FIRST = 4'h1;
	localparam logic [3:0] TRIG_EVT_LAST  = 4'h8;
	localparam logic [3:0] TRIG_PIN       = 4'h9;
	localparam logic [3:0] TRIG_ALWAYS    = 4'hf;
	localparam logic [15:0] TRIG_SEL_RST  = 16'h0000;
	localparam logic [7:0]  PRIO_RST      = 8'he4;
	localparam logic [2:0]  AVG_EXP_MAX   = 3'h6;
	localparam logic [2:0]  AVG_OFF       = 3'h0;

	function automatic int seq_depth(input int s);
		return (s == 0) ? 8 : (s == 3) ? 1 : 4;
	endfunction

endpackage

//--- shared/ssc_sample_if.sv
// One sample word with its valid strobe, passed between sequencer parts.
// Assumes source and sink share the system clock.
`timescale 1ns/10ps
interface ssc_sample_if #(parameter int W = 12);
	logic         valid;
	logic [W-1:0] data;
	modport src (output valid, output data);
	modport dst (input valid, input data);
endinterface

//--- core/ssc_avg.sv
// Hardware averager: sums 2^exp samples and delivers their mean.
// Assumes samples arrive at most one per cycle on the system clock.
`timescale 1ns/10ps
module ssc_avg #(
	parameter int W = 12
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [2:0] i_exp,
	input  wire logic       i_clear,
	ssc_sample_if.dst       smp,
	ssc_sample_if.src       res
);
	localparam int AW = W + 6;

	logic [AW-1:0] acc_q;
	logic [6:0]    cnt_q;
	logic          vld_q;
	logic [W-1:0]  res_q;

	wire [6:0]    target  = 7'h01 << i_exp;
	wire [AW-1:0] sum     = acc_q + AW'(smp.data);
	wire          last    = (cnt_q + 7'h01) == target;
	wire [AW-1:0] shifted = sum >> i_exp;

	// Exponent zero gives target one: every sample passes straight through
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_clear) begin
			acc_q <= '0;
			cnt_q <= '0;
			vld_q <= 1'b0;
			res_q <= '0;
		end else begin
			vld_q <= smp.valid && last;
			if (smp.valid && last) begin
				acc_q <= '0;
				cnt_q <= '0;
				res_q <= shifted[W-1:0];
			end else if (smp.valid) begin
				acc_q <= sum;
				cnt_q <= cnt_q + 7'h01;
			end
		end
	end

	assign res.valid = vld_q;
	assign res.data  = res_q;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	avg_count_bound_a: assert property (cnt_q < target || $changed(i_exp))
		else $error("averager count passed its factor");
	avg_bypass_a: assert property (smp.valid && i_exp == 3'h0 && !i_clear |=>
		vld_q && res_q == $past(smp.data))
		else $error("averager off but sample not passed through");
endmodule

//--- core/ssc_fifo.sv
// Result FIFO of one sequencer, depth set by that sequencer's step count.
// Assumes push and pop come from the system clock domain.
`timescale 1ns/10ps
module ssc_fifo #(
	parameter int DEPTH = 8,
	parameter int W     = 12,
	parameter int LW    = 4
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	ssc_sample_if.dst          push,
	input  wire logic          i_pop,
	output logic [W-1:0]       o_data,
	output logic [LW-1:0]      o_level,
	output logic               o_full
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic [LW-1:0] cnt_q;

	wire do_push = push.valid && (cnt_q != LVL_FULL);
	wire do_pop  = i_pop && (cnt_q != '0);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push)
				wp_q <= (wp_q == PTR_LAST) ? '0 : wp_q + 1'b1;
			if (do_pop)
				rp_q <= (rp_q == PTR_LAST) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + LW'(do_push) - LW'(do_pop);
		end
	end

	// Storage needs no reset; level gates every pop, but o_data shows mem_q[rp_q] even when empty
	always_ff @(posedge i_clk) begin
		if (do_push)
			mem_q[wp_q] <= push.data;
	end

	assign o_data  = mem_q[rp_q];
	assign o_level = cnt_q;
	assign o_full  = (cnt_q == LVL_FULL);
endmodule

//--- bench/ssc_conv_model.sv
// Behavioural converter facing the sequencer: answers each start with done.
// Assumes start is a one-cycle pulse and the channel is stable until done.
`timescale 1ns/10ps
module ssc_conv_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_start,
	input  wire logic [2:0]  i_channel,
	input  wire logic        i_slow,
	output logic             o_done,
	output logic [11:0]      o_data
);
	logic [2:0] ch_q;
	int         wait_q;
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		// Data outside done is not held, so a late sample shows up
		o_data <= ~o_data;
		if (!i_rst_n) begin
			wait_q <= 0;
		end else if (i_start) begin
			ch_q   <= i_channel;
			wait_q <= i_slow ? 6 : 1;
		end else if (wait_q == 1) begin
			o_done <= 1'b1;
			o_data <= {1'b0, ch_q, 8'h35};
			wait_q <= 0;
		end else if (wait_q > 1) begin
			wait_q <= wait_q - 1;
		end
	end
	initial o_data = 12'h000;
endmodule

//--- bench/test_ssc_top.sv
// Self-checking bench of the sequencer control with a converter model.
// Assumes the register map and step layout given in ssc_pkg.
`timescale 1ns/10ps
module test_ssc_top;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic [7:0]  i_trig_evt = 8'h00;
	logic        o_conv_start;
	logic [2:0]  o_conv_channel;
	logic        conv_done;
	logic [11:0] conv_data;
	logic [3:0]  o_seq_irq;
	logic        slow = 1'b0;
	logic [31:0] seed = 32'h6cf2b0ee;
	logic [31:0] d;
	logic [2:0]  c [4];
	logic        trig_pin = 1'b0;
	int          n_errors = 0;
	int          compares = 0;
	int          nconv = 0;
	logic [2:0]  chq [$];
	int          f [7] = '{0, 2, 4, 8, 16, 32, 64};

	always #20 i_clk = ~i_clk;

	ssc_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig_evt(i_trig_evt),
		.i_trig_pin(trig_pin), .o_conv_start(o_conv_start), .o_conv_channel(o_conv_channel),
		.i_conv_done(conv_done), .i_conv_data(conv_data), .o_seq_irq(o_seq_irq));
	ssc_conv_model conv (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(o_conv_start),
		.i_channel(o_conv_channel), .i_slow(slow), .o_done(conv_done), .o_data(conv_data));

	always @(posedge i_clk) begin
		if (o_conv_start === 1'b1) begin
			nconv++;
			chq.push_back(o_conv_channel);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] smp(input logic [2:0] ch);
		return {21'h0, ch, 8'h35};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= v;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		@(negedge i_clk);
		v = o_rdata;
	endtask
	task automatic trig(input logic [31:0] m);
		seed = lfsr(seed);
		slow <= seed[0];
		wr(8'h10, m);
	endtask
	// Poll the raw status until every bit of m is set
	task automatic wait_raw(input logic [3:0] m);
		logic [31:0] v;
		v = 32'h0;
		for (int k = 0; k < 2000 && (v[3:0] & m) != m; k++) rd(8'h14, v);
		chk({28'h0, v[3:0] & m}, {28'h0, m});
	endtask
	task automatic end_of_test;
		$display("compares %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge i_clk);
		n_errors++;
		end_of_test;
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(8'h04, d);
		chk(d, 32'h0);
		rd(8'h18, d);
		chk(d, 32'h0);
		rd(8'h14, d);
		chk(d, 32'h0);
		rd(8'h0c, d);
		chk(d, 32'he4);
		rd(8'h1c, d);
		chk(d, 32'h0);
		wr(8'h00, 32'hf);
		// Pass 0 with interrupt disabled, pass 1 enabled after a clear
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++) begin
				seed = lfsr(seed);
				c[i] = 3'(seed % 5);
				wr(8'h80 | 8'(i << 2), {27'h0, (i == 2) ? 2'b11 : 2'b00, c[i]});
			end
			trig(32'h1);
			wait_raw(4'h1);
			rd(8'h34, d);
			chk(d, 32'h3);
			for (int i = 0; i < 3; i++) begin
				rd(8'h24, d);
				chk(d, smp(c[i]));
			end
			rd(8'h1c, d);
			chk(d, 32'(p));
			chk({28'h0, o_seq_irq}, 32'(p));
			wr(8'h14, 32'h1);
			rd(8'h14, d);
			chk(d, 32'h0);
			chk({28'h0, o_seq_irq}, 32'h0);
			wr(8'h18, 32'h1);
		end
		// Simultaneous triggers: sequencer 2 holds the top priority
		wr(8'h0c, 32'hc6);
		wr(8'ha0, 32'h19);
		wr(8'hc0, 32'h1c);
		chq.delete();
		trig(32'h6);
		wait_raw(4'h6);
		chk({29'h0, chq[0]}, 32'h4);
		chk({29'h0, chq[1]}, 32'h1);
		rd(8'h28, d);
		chk(d, smp(3'h1));
		rd(8'h2c, d);
		chk(d, smp(3'h4));
		wr(8'h14, 32'h6);
		// Event source on sequencer 1 refuses the processor trigger
		wr(8'h08, 32'h10);
		nconv = 0;
		trig(32'h2);
		repeat (30) @(posedge i_clk);
		chk(32'(nconv), 32'h0);
		i_trig_evt <= 8'h01;
		@(posedge i_clk);
		i_trig_evt <= 8'h00;
		wait_raw(4'h2);
		rd(8'h28, d);
		chk(d, smp(3'h1));
		wr(8'h14, 32'h2);
		// Pin source on sequencer 1: a rising edge starts it
		wr(8'h08, 32'h90);
		trig_pin <= 1'b1;
		repeat (4) @(posedge i_clk);
		trig_pin <= 1'b0;
		wait_raw(4'h2);
		rd(8'h28, d);
		chk(d, smp(3'h1));
		wr(8'h14, 32'h2);
		// Averaging factors on the single-step sequencer
		wr(8'he0, 32'h1a);
		for (int i = 0; i < 7; i++) begin
			wr(8'h04, f[i]);
			rd(8'h04, d);
			chk(d, f[i]);
			nconv = 0;
			trig(32'h8);
			wait_raw(4'h8);
			chk(32'(nconv), (f[i] == 0) ? 32'h1 : f[i]);
			rd(8'h34, d);
			chk(d, 32'h1000);
			rd(8'h30, d);
			chk(d, smp(3'h2));
			wr(8'h14, 32'h8);
		end
		wr(8'h04, 32'h3);
		rd(8'h04, d);
		chk(d, 32'h40);
		wr(8'h04, 32'h0);
		// Second trigger with an unread result
		rd(8'h20, d);
		chk(d, 32'h0);
		trig(32'h8);
		wait_raw(4'h8);
		wr(8'h14, 32'h8);
		trig(32'h8);
		wait_raw(4'h8);
		rd(8'h20, d);
		chk(d, 32'h8);
		wr(8'h20, 32'h8);
		rd(8'h20, d);
		chk(d, 32'h0);
		// Always source re-arms; the unread entry flags overflow again
		wr(8'h08, 32'hf000);
		repeat (40) @(posedge i_clk);
		wr(8'h08, 32'h0);
		rd(8'h20, d);
		chk(d, 32'h8);
		rd(8'h34, d);
		chk(d, 32'h1000);
		end_of_test;
	end
endmodule
